/* File: rtl/aas_pkg.sv */
package aas_pkg;

  // ==========================================
  // register map
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int CTRL_LOOP_BIT = 0;
  localparam int CTRL_TEST_BIT = 1;
  localparam int CTRL_HOLD_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int STAT_LT_LSB = 0;
  localparam int STAT_NT_LSB = 4;
  localparam int STAT_TRANSP_BIT = 8;
  localparam int STAT_ARMED_BIT = 9;

  // ==========================================
  // timing and widths
  // superframes with the warning bit at zero before going silent
  localparam logic [2:0] WARN_SUPERFRAMES = 3'h3;
  // two B channels of 8 bits plus two D bits
  localparam int PAYLOAD_W = 18;

  // ==========================================
  // line signal codes towards the terminal side
  localparam logic [1:0] SIG_SILENCE = 2'h0;
  localparam logic [1:0] SIG_WAKE = 2'h1;
  localparam logic [1:0] SIG_SYNC = 2'h2;
  localparam logic [1:0] SIG_ACTIVE = 2'h3;

  // ==========================================
  // types
  typedef enum logic [1:0] {
    LT_IDLE = 2'b00,
    LT_ALERT = 2'b01,
    LT_SILENT = 2'b10
  } aas_lt_state_t;

  typedef enum logic [2:0] {
    NT_RESET = 3'b000,
    NT_AWAIT = 3'b001,
    NT_LINEUP = 3'b010,
    NT_TERMUP = 3'b011,
    NT_ACTIVE = 3'b100,
    NT_HOLD = 3'b101,
    NT_TEST = 3'b110
  } aas_nt_state_t;

  typedef struct packed {
    logic activated;
    logic deactivated;
    logic halfUp;
    logic failed;
  } aas_prim_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } aas_reg_req_t;

endpackage

/* File: rtl/aas_warn_timer.sv */
`timescale 1ns/1ps
module aas_warn_timer
  import aas_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic superframeTick,
  output logic [2:0] tickCount,
  output logic done
);

  // ==========================================
  // superframe counter
  // first tick only aligns: the alert may start mid-superframe
  assign done = run && superframeTick && (tickCount == WARN_SUPERFRAMES);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tickCount <= 3'h0;
    end else if (!run) begin
      tickCount <= 3'h0;
    end else if (superframeTick && tickCount != WARN_SUPERFRAMES) begin
      tickCount <= tickCount + 3'h1;
    end
  end

endmodule

/* File: rtl/aas_activation_seq.sv */
`timescale 1ns/1ps
// How it works
// - deactivate request enters alerting, warning bit zero for three full superframes
// - after the warning interval the line side sends silence
// - after a failed wake-up, a fresh idle-to-wake edge is needed
// - leaving test returns to prior state unless indication bits changed
// - payload holds its last value until both activation bits are set
// - loopback makes the payload transparent whatever the activation bits
// - hold state freezes activation bit and signal code outputs
// - terminal activation and line sync accepted in either order
module aas_activation_seq
  import aas_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire aas_reg_req_t regReq,
  output logic [31:0] regRdata,
  input wire logic deactivateRequestPrimitive,
  input wire logic activateRequestPrimitive,
  input wire logic superframeTick,
  output logic deaWarnBit,
  output logic lineSilence,
  input wire logic terminalWakeupPin,
  input wire logic terminalActivePin,
  input wire logic lineSyncedPin,
  input wire logic wakeupFail,
  input wire logic actRx,
  input wire logic uoaRx,
  output logic actTx,
  output logic [1:0] ntSignal,
  input wire logic [PAYLOAD_W-1:0] payloadIn,
  output logic [PAYLOAD_W-1:0] payloadOut,
  output aas_prim_t prim
);

  aas_lt_state_t ltState, ltNext;
  aas_nt_state_t ntState, ntNext, savedState;
  logic [2:0] ctrl;
  logic [2:0] pinMeta, pinSync;
  logic wakePrev, armed, savedAct, savedUoa;
  logic [2:0] tickCount;
  logic warnDone;
  logic wakeRise, wake, termActive, lineSynced;
  logic loopbackEn, testBit, holdBit, transparent, bitsChanged;
  logic [1:0] next_ntSignal;
  logic next_actTx;
  logic [31:0] statusWord, next_rdata;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================
  // pin synchronisers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end else begin
      pinMeta <= {lineSyncedPin, terminalActivePin, terminalWakeupPin};
      pinSync <= pinMeta;
    end
  end

  assign wake = pinSync[0];
  assign termActive = pinSync[1];
  assign lineSynced = pinSync[2];
  assign wakeRise = wake && !wakePrev;
  assign loopbackEn = ctrl[CTRL_LOOP_BIT];
  assign testBit = ctrl[CTRL_TEST_BIT];
  assign holdBit = ctrl[CTRL_HOLD_BIT];

  // ==========================================
  // line-side deactivation sequence
  aas_warn_timer u_warn (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(ltState == LT_ALERT),
    .superframeTick(superframeTick),
    .tickCount(tickCount),
    .done(warnDone)
  );

  always_comb begin
    ltNext = ltState;
    case (ltState)
      LT_IDLE: if (deactivateRequestPrimitive) ltNext = LT_ALERT;
      LT_ALERT: if (warnDone) ltNext = LT_SILENT;
      LT_SILENT: if (activateRequestPrimitive) ltNext = LT_IDLE;
      default: ltNext = LT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ltState <= LT_IDLE;
      deaWarnBit <= 1'b1;
      lineSilence <= 1'b0;
    end else begin
      ltState <= ltNext;
      deaWarnBit <= (ltNext != LT_ALERT);
      lineSilence <= (ltNext == LT_SILENT);
    end
  end

  // ==========================================
  // customer-side activation state machine
  assign bitsChanged = (actRx != savedAct) || (uoaRx != savedUoa);

  always_comb begin
    ntNext = ntState;
    case (ntState)
      NT_RESET: begin
        if (armed && wake) ntNext = NT_AWAIT;
        else if (lineSynced) ntNext = NT_LINEUP;
      end
      NT_AWAIT: begin
        if (lineSynced) ntNext = NT_LINEUP;
        else if (termActive) ntNext = NT_TERMUP;
      end
      NT_LINEUP: begin
        if (!lineSynced) ntNext = NT_RESET;
        else if (termActive) ntNext = NT_ACTIVE;
      end
      NT_TERMUP: if (lineSynced) ntNext = NT_ACTIVE;
      NT_ACTIVE: if (!lineSynced) ntNext = NT_RESET;
      NT_HOLD: if (!holdBit) ntNext = savedState;
      NT_TEST: begin
        if (!testBit) ntNext = bitsChanged ? NT_RESET : savedState;
      end
      default: ntNext = NT_RESET;
    endcase
    if (ntState != NT_TEST && ntState != NT_HOLD) begin
      if (testBit) ntNext = NT_TEST;
      else if (holdBit && ntState != NT_RESET && ntState != NT_AWAIT) ntNext = NT_HOLD;
    end
    if (wakeupFail && ntState != NT_TEST) ntNext = NT_RESET;
  end

  // outputs follow the next state, so hold and test simply keep them
  always_comb begin
    next_actTx = actTx;
    next_ntSignal = ntSignal;
    case (ntNext)
      NT_RESET: begin
        next_actTx = 1'b0;
        next_ntSignal = SIG_SILENCE;
      end
      NT_AWAIT: begin
        next_actTx = 1'b0;
        next_ntSignal = SIG_WAKE;
      end
      NT_LINEUP, NT_TERMUP: begin
        next_actTx = 1'b0;
        next_ntSignal = SIG_SYNC;
      end
      NT_ACTIVE: begin
        next_actTx = 1'b1;
        next_ntSignal = SIG_ACTIVE;
      end
      default: begin
        next_actTx = actTx;
        next_ntSignal = ntSignal;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ntState <= NT_RESET;
      savedState <= NT_RESET;
      savedAct <= 1'b0;
      savedUoa <= 1'b0;
      actTx <= 1'b0;
      ntSignal <= SIG_SILENCE;
    end else begin
      ntState <= ntNext;
      actTx <= next_actTx;
      ntSignal <= next_ntSignal;
      if ((ntNext == NT_TEST || ntNext == NT_HOLD) && ntState != ntNext) begin
        savedState <= ntState;
        savedAct <= actRx;
        savedUoa <= uoaRx;
      end
    end
  end

  // a wake level held through a failure does not re-arm; set beats clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wakePrev <= 1'b0;
      armed <= 1'b0;
    end else begin
      wakePrev <= wake;
      if (wakeRise) armed <= 1'b1;
      else if (wakeupFail && ntState != NT_TEST) armed <= 1'b0;
    end
  end

  // ==========================================
  // payload gating
  assign transparent = loopbackEn || (actTx && actRx);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      payloadOut <= '0;
    end else if (transparent) begin
      payloadOut <= payloadIn;
    end
  end

  // ==========================================
  // primitives towards management
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prim <= '0;
    end else begin
      prim.activated <= (ntNext == NT_ACTIVE) && (ntState != NT_ACTIVE);
      prim.deactivated <= (ltNext == LT_SILENT) && (ltState != LT_SILENT);
      prim.halfUp <= (ntNext == NT_LINEUP || ntNext == NT_TERMUP) && (ntState != ntNext);
      prim.failed <= wakeupFail && (ntState != NT_TEST);
    end
  end

  // ==========================================
  // register port
  assign statusWord = {22'h0, armed, transparent, 1'b0, ntState, 2'h0, ltState};
  assign next_rdata = (regReq.addr == ADDR_CTRL) ? {29'h0, ctrl} :
                      (regReq.addr == ADDR_STATUS) ? statusWord : 32'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      regRdata <= 32'h0;
    end else begin
      if (regReq.wr && regReq.addr == ADDR_CTRL) ctrl <= regReq.wdata[2:0];
      regRdata <= regReq.rd ? next_rdata : 32'h0;
    end
  end

  // ==========================================
  // checks
  alert_enter_a: assert property ((ltState == LT_IDLE && deactivateRequestPrimitive) |=>
    (ltState == LT_ALERT && !deaWarnBit)) else $error("alerting not entered");
  warn_length_a: assert property ((ltState == LT_ALERT && ltNext == LT_SILENT) |->
    (tickCount == WARN_SUPERFRAMES && superframeTick)) else $error("warning interval too short");
  silence_after_a: assert property ((ltState == LT_ALERT && warnDone) |=>
    (lineSilence && deaWarnBit)) else $error("silence not sent after warning");
  rearm_block_a: assert property ((ntState == NT_RESET && !armed) |=>
    (ntState != NT_AWAIT)) else $error("awaiting entered without fresh wake edge");
  test_return_a: assert property ((ntState == NT_TEST && !testBit && !bitsChanged && !wakeupFail) |=>
    (ntState == $past(savedState))) else $error("test exit lost prior state");
  payload_hold_a: assert property (!transparent |=>
    $stable(payloadOut)) else $error("payload changed while not transparent");
  loop_pass_a: assert property (loopbackEn |=>
    (payloadOut == $past(payloadIn))) else $error("loopback not transparent");
  hold_freeze_a: assert property ((ntState == NT_HOLD && ntNext == NT_HOLD) |=>
    ($stable(actTx) && $stable(ntSignal))) else $error("hold state changed outputs");
  either_order_a: assert property ((((ntState == NT_LINEUP && termActive && lineSynced) ||
    (ntState == NT_TERMUP && lineSynced)) && !testBit && !holdBit && !wakeupFail) |=>
    (ntState == NT_ACTIVE && prim.activated))
    else $error("activation order mishandled");
  prim_pulse_a: assert property (prim.activated |=> !prim.activated)
    else $error("primitive longer than one cycle");

endmodule

/* File: verification/aas_far_end.sv */
`timescale 1ns/1ps
module aas_far_end
  import aas_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic actTx,
  input wire logic goSync,
  input wire logic partialUp,
  input wire logic ignoreAct,
  output logic lineSyncedPin,
  output logic actRx,
  output logic uoaRx
);
  // ==========================================
  // far line end
  // echoes the activation bit one clock cycle late, like a slow far end would
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lineSyncedPin <= 1'b0;
      actRx <= 1'b0;
      uoaRx <= 1'b0;
    end else begin
      lineSyncedPin <= goSync;
      actRx <= actTx & ~ignoreAct;
      uoaRx <= partialUp;
    end
  end
endmodule

/* File: verification/access_activation_sequencing_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module access_activation_sequencing_test;
  import aas_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  aas_reg_req_t regReq = '0;
  logic [31:0] regRdata;
  logic [31:0] rdv;
  logic [31:0] seed = 32'h4A4BCC2D;
  logic deaReq = 1'b0, actReq = 1'b0, tick = 1'b0, wake = 1'b0, termAct = 1'b0, fail = 1'b0;
  logic goSync = 1'b0, partialUp = 1'b0, ignoreAct = 1'b0;
  logic deaWarnBit, lineSilence, lineSyncedPin, actRx, uoaRx, actTx;
  logic [1:0] ntSignal;
  logic [PAYLOAD_W-1:0] payloadIn = '0;
  logic [PAYLOAD_W-1:0] payloadOut;
  logic [PAYLOAD_W-1:0] held;
  aas_prim_t prim;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #50 clk_sys = ~clk_sys;

  aas_activation_seq dut_u (.clk_sys, .rst, .regReq, .regRdata, .deactivateRequestPrimitive(deaReq),
    .activateRequestPrimitive(actReq), .superframeTick(tick), .deaWarnBit, .lineSilence,
    .terminalWakeupPin(wake), .terminalActivePin(termAct), .lineSyncedPin, .wakeupFail(fail),
    .actRx, .uoaRx, .actTx, .ntSignal, .payloadIn, .payloadOut, .prim);

  aas_far_end far_u (.clk_sys, .rst, .actTx, .goSync, .partialUp, .ignoreAct, .lineSyncedPin,
    .actRx, .uoaRx);

  // ==========================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // hold and test are only entered from active here, so their frozen code is active
  function automatic logic [1:0] sigFor(input aas_nt_state_t s);
    if (s == NT_RESET) return SIG_SILENCE;
    if (s == NT_AWAIT) return SIG_WAKE;
    if (s == NT_LINEUP || s == NT_TERMUP) return SIG_SYNC;
    return SIG_ACTIVE;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys) regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) regReq.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys) regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) regReq.rd <= 1'b0;
    #1 rdv = regRdata;
  endtask

  task automatic ntIs(input aas_nt_state_t s);
    for (int i = 0; i < 12; i++) begin
      rd(ADDR_STATUS);
      if (rdv[6:4] === s) break;
    end
    `CHK(rdv[6:4], s)
    `CHK(ntSignal, sigFor(s))
  endtask

  task automatic newPayload();
    @(posedge clk_sys);
    seed = lfsr(seed);
    payloadIn <= seed[PAYLOAD_W-1:0];
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // cut a hang short, the sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1 `CHK({deaWarnBit, lineSilence, actTx, ntSignal, payloadOut, prim}, {1'b1, 26'h0})
    rd(4'h8);
    `CHK(rdv, 32'h0)
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_CTRL);
    `CHK(rdv, 32'h1)
    @(posedge clk_sys);
    #1 `CHK(regRdata, 32'h0)
    repeat (6) begin
      newPayload();
      @(posedge clk_sys);
      #1 `CHK(payloadOut, payloadIn)
    end
    wr(ADDR_CTRL, 32'h0);
    @(posedge clk_sys);
    #1 held = payloadOut;
    newPayload();
    repeat (3) @(posedge clk_sys);
    #1 `CHK(payloadOut, held)
    // deactivation warning then silence
    @(posedge clk_sys) deaReq <= 1'b1;
    @(posedge clk_sys) deaReq <= 1'b0;
    #1 `CHK(deaWarnBit, 1'b0)
    @(posedge clk_sys);
    for (int k = 1; k <= 4; k++) begin
      @(posedge clk_sys) tick <= 1'b1;
      @(posedge clk_sys) tick <= 1'b0;
      #1 `CHK({lineSilence, deaWarnBit}, {k == 4, k == 4})
    end
    `CHK(prim, 4'b0100)
    @(posedge clk_sys) actReq <= 1'b1;
    #1 `CHK(prim, 4'b0000)
    @(posedge clk_sys) actReq <= 1'b0;
    rd(ADDR_STATUS);
    `CHK({rdv[1:0], lineSilence}, 3'b000)
    // line sync first, then terminal
    @(posedge clk_sys) wake <= 1'b1;
    ntIs(NT_AWAIT);
    @(posedge clk_sys) goSync <= 1'b1;
    ntIs(NT_LINEUP);
    @(posedge clk_sys) termAct <= 1'b1;
    for (int i = 0; i < 10 && prim.activated !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(prim, 4'b1000)
    ntIs(NT_ACTIVE);
    newPayload();
    repeat (2) @(posedge clk_sys);
    #1 `CHK(payloadOut, payloadIn)
    // hold freezes outputs while the line drops
    wr(ADDR_CTRL, 32'h4);
    ntIs(NT_HOLD);
    @(posedge clk_sys) goSync <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 `CHK({actTx, ntSignal}, {1'b1, SIG_ACTIVE})
    @(posedge clk_sys) goSync <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(ADDR_CTRL, 32'h0);
    ntIs(NT_ACTIVE);
    // test state, plain exit then exit after a change of the partial bit
    wr(ADDR_CTRL, 32'h2);
    ntIs(NT_TEST);
    wr(ADDR_CTRL, 32'h0);
    ntIs(NT_ACTIVE);
    wr(ADDR_CTRL, 32'h2);
    ntIs(NT_TEST);
    @(posedge clk_sys) partialUp <= 1'b1;
    wake <= 1'b0;
    goSync <= 1'b0;
    termAct <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(ADDR_CTRL, 32'h0);
    ntIs(NT_RESET);
    // failed wake-up with the wake signal held
    @(posedge clk_sys) wake <= 1'b1;
    partialUp <= 1'b0;
    ntIs(NT_AWAIT);
    @(posedge clk_sys) fail <= 1'b1;
    @(posedge clk_sys) fail <= 1'b0;
    #1 `CHK(prim, 4'b0001)
    repeat (8) @(posedge clk_sys);
    ntIs(NT_RESET);
    `CHK(rdv[STAT_ARMED_BIT], 1'b0)
    @(posedge clk_sys) wake <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wake <= 1'b1;
    ntIs(NT_AWAIT);
    // terminal first, then line sync
    @(posedge clk_sys) termAct <= 1'b1;
    for (int i = 0; i < 10 && prim.halfUp !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(prim, 4'b0010)
    ntIs(NT_TERMUP);
    @(posedge clk_sys) goSync <= 1'b1;
    ntIs(NT_ACTIVE);
    // far end takes no action on the activation bit
    @(posedge clk_sys) ignoreAct <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 held = payloadOut;
    newPayload();
    rd(ADDR_STATUS);
    `CHK({rdv[STAT_TRANSP_BIT], payloadOut}, {1'b0, held})
    stop_test();
  end
endmodule
